// >>> design/slom_pkg.sv
package slom_pkg;
	// ==========================================
	// Register offsets
	localparam logic [7:0] ADDR_MASTER_POLL = 8'h00;
	localparam logic [7:0] ADDR_TX_CTRL     = 8'h15;
	localparam logic [7:0] ADDR_RX_STATUS   = 8'h18;
	localparam logic [7:0] ADDR_RX_IRQ      = 8'h19;
	localparam logic [7:0] ADDR_B2_LOW      = 8'h1a;
	localparam logic [7:0] ADDR_B2_MID      = 8'h1b;
	localparam logic [7:0] ADDR_B2_HIGH     = 8'h1c;
	localparam logic [7:0] ADDR_FEBE_LOW    = 8'h1d;
	localparam logic [7:0] ADDR_FEBE_MID    = 8'h1e;
	localparam logic [7:0] ADDR_FEBE_HIGH   = 8'h1f;
	// ==========================================
	// Field positions
	localparam int BIT_FORCE_ZERO   = 2;
	localparam int BIT_B1_INVERT    = 1;
	localparam int BIT_A1_CORRUPT   = 0;
	localparam int BIT_ONCE_MODE    = 7;
	localparam int BIT_ALARM_STAT   = 1;
	localparam int BIT_RDI_STAT     = 0;
	localparam int IRQ_EN_LSB       = 4;
	localparam int FLAG_FEBE        = 3;
	localparam int FLAG_B2          = 2;
	localparam int FLAG_ALARM       = 1;
	localparam int FLAG_RDI         = 0;
	// ==========================================
	// Widths, reset values, limits
	localparam int CNT_W            = 20;
	localparam int ERR_W            = 5;
	localparam int TXC_W            = 3;
	localparam int IRQ_W            = 4;
	localparam logic [TXC_W-1:0] TX_CTRL_RST = 3'h0;
	localparam logic [IRQ_W-1:0] IRQ_EN_RST  = 4'h0;
	localparam logic [CNT_W-1:0] CNT_RST     = 20'h00000;
	localparam logic [7:0] A1_MSB_MASK       = 8'h80;
	localparam logic [7:0] BYTE_ZERO         = 8'h00;
	localparam logic [ERR_W-1:0] MAX_ERR_STS1  = 5'h08;
	localparam logic [ERR_W-1:0] MAX_ERR_STS3C = 5'h18;
	localparam logic [ERR_W-1:0] ONE_ERR       = 5'h01;
	localparam logic [ERR_W-1:0] NO_ERR        = 5'h00;
endpackage

// >>> design/slom_top.sv
// Contract
// R1: Force-zero control drives every outgoing line bit to zero while set.
// R2: Parity-invert control inverts the computed B1 byte before transmission.
// R3: Framing-corrupt control flips A1 MSB, sending 0x76 instead of 0xf6.
// R4: Once-per-frame mode adds exactly one for a frame with B2 errors.
// R5: Otherwise add frame B2 count, at most 8 (STS-1) or 24 (STS-3c).
// R6: Line alarm status reads at bit 1 of status register.
// R7: Remote defect status reads at bit 0 of status register.
// R8: Far-end block error enable bit 7 gates its interrupt.
// R9: Line parity error enable bit 6 gates its interrupt.
// R10: Line alarm enable bit 5 gates interrupt on alarm change.
// R11: Remote defect enable bit 4 gates interrupt on defect change.
// R12: Far-end block error flag bit 3 sets on event, clears on read.
// R13: Line parity flag bit 2 sets on B2 error, clears on read.
// R14: Alarm change flag bit 1 sets on change, clears on read.
// R15: Defect change flag bit 0 sets on change, clears on read.
// R16: 20-bit parity counter, low byte at 0x1a, middle at 0x1b.
// R17: Far-end counter bits 15:8 readable at 0x1e.
// R18: Counter byte write moves count to holding register, restarts, loses nothing.
// R19: Write to address 0x00 polls all counters the same way.
// R20: Interrupt output high while any enabled flag is set.
module slom_top (
	input  wire logic                       i_clock,
	input  wire logic                       i_rstn,
	input  wire logic                       i_cpu_rd,
	input  wire logic                       i_cpu_wr,
	input  wire logic [7:0]                 i_cpu_addr,
	input  wire logic [7:0]                 i_cpu_wdata,
	output logic      [7:0]                 o_cpu_rdata,
	output logic                            o_cpu_rvalid,
	output logic                            o_irq,
	input  wire logic [7:0]                 i_tx_byte,
	input  wire logic                       i_tx_is_a1,
	input  wire logic                       i_tx_is_b1,
	output logic      [7:0]                 o_tx_byte,
	input  wire logic                       i_rate_sts1,
	input  wire logic                       i_rx_frame_end,
	input  wire logic [slom_pkg::ERR_W-1:0] i_rx_b2_errs,
	input  wire logic [slom_pkg::ERR_W-1:0] i_rx_febe_errs,
	input  wire logic                       i_rx_line_alarm,
	input  wire logic                       i_rx_remote_defect
);
	import slom_pkg::*;

	// ==========================================
	// State
	typedef struct packed {
		logic [TXC_W-1:0] tx_ctrl;
		logic             once_mode;
		logic [IRQ_W-1:0] irq_en;
		logic [IRQ_W-1:0] flags;
		logic             alarm_prev;
		logic             rdi_prev;
		logic [CNT_W-1:0] b2_acc;
		logic [CNT_W-1:0] b2_hold;
		logic [CNT_W-1:0] febe_acc;
		logic [CNT_W-1:0] febe_hold;
		logic [7:0]       tx_byte;
		logic [7:0]       rdata;
		logic             rvalid;
		logic             irq;
	} slom_state_t;

	slom_state_t state_q;
	slom_state_t state_d;

	logic [ERR_W-1:0] max_err;
	logic [ERR_W-1:0] b2_clip;
	logic [ERR_W-1:0] febe_clip;
	logic [ERR_W-1:0] b2_inc;
	logic [ERR_W-1:0] febe_inc;
	logic             poll;
	logic             irq_read;
	logic [IRQ_W-1:0] events;

	// ==========================================
	// Frame error increments
	always_comb begin
		max_err   = i_rate_sts1 ? MAX_ERR_STS1 : MAX_ERR_STS3C;
		b2_clip   = (i_rx_b2_errs > max_err) ? max_err : i_rx_b2_errs;
		febe_clip = (i_rx_febe_errs > max_err) ? max_err : i_rx_febe_errs;
		b2_inc    = NO_ERR;
		febe_inc  = NO_ERR;
		if (i_rx_frame_end) begin
			if (state_q.once_mode) begin
				b2_inc = (b2_clip != NO_ERR) ? ONE_ERR : NO_ERR; // R4
			end else begin
				b2_inc = b2_clip; // R5
			end
			febe_inc = febe_clip;
		end
	end

	// Any counter byte write or the master address polls both counters
	always_comb begin
		poll = 1'b0;
		if (!i_cpu_wr) begin
			poll = 1'b0;
		end else if (i_cpu_addr == ADDR_MASTER_POLL) begin
			poll = 1'b1; // R19
		end else if (i_cpu_addr >= ADDR_B2_LOW && i_cpu_addr <= ADDR_FEBE_HIGH) begin
			poll = 1'b1; // R18
		end
	end

	assign irq_read = i_cpu_rd && (i_cpu_addr == ADDR_RX_IRQ);

	always_comb begin
		events             = '0;
		events[FLAG_FEBE]  = i_rx_frame_end && (febe_clip != NO_ERR);
		events[FLAG_B2]    = i_rx_frame_end && (b2_clip != NO_ERR);
		events[FLAG_ALARM] = i_rx_line_alarm != state_q.alarm_prev;
		events[FLAG_RDI]   = i_rx_remote_defect != state_q.rdi_prev;
	end

	// ==========================================
	// Next state
	always_comb begin
		state_d            = state_q;
		state_d.alarm_prev = i_rx_line_alarm;
		state_d.rdi_prev   = i_rx_remote_defect;
		state_d.rvalid     = i_cpu_rd;

		// Transmit byte path; zero forcing has top priority
		state_d.tx_byte = i_tx_byte;
		if (state_q.tx_ctrl[BIT_FORCE_ZERO]) begin
			state_d.tx_byte = BYTE_ZERO; // R1
		end else if (i_tx_is_b1 && state_q.tx_ctrl[BIT_B1_INVERT]) begin
			state_d.tx_byte = ~i_tx_byte; // R2
		end else if (i_tx_is_a1 && state_q.tx_ctrl[BIT_A1_CORRUPT]) begin
			state_d.tx_byte = i_tx_byte ^ A1_MSB_MASK; // R3
		end

		// Counters: in-flight increment goes to holding on poll
		if (poll) begin
			state_d.b2_hold   = state_q.b2_acc + CNT_W'(b2_inc); // R18
			state_d.febe_hold = state_q.febe_acc + CNT_W'(febe_inc);
			state_d.b2_acc    = CNT_RST;
			state_d.febe_acc  = CNT_RST;
		end else begin
			state_d.b2_acc   = state_q.b2_acc + CNT_W'(b2_inc); // R16
			state_d.febe_acc = state_q.febe_acc + CNT_W'(febe_inc);
		end

		// Flags: set wins over clear-on-read
		state_d.flags = (irq_read ? '0 : state_q.flags) | events; // R12 R13 R14 R15

		// Register writes
		if (i_cpu_wr && i_cpu_addr == ADDR_TX_CTRL) begin
			state_d.tx_ctrl = i_cpu_wdata[TXC_W-1:0];
		end else if (i_cpu_wr && i_cpu_addr == ADDR_RX_STATUS) begin
			state_d.once_mode = i_cpu_wdata[BIT_ONCE_MODE];
		end else if (i_cpu_wr && i_cpu_addr == ADDR_RX_IRQ) begin
			state_d.irq_en = i_cpu_wdata[IRQ_EN_LSB +: IRQ_W];
		end

		// Register reads
		state_d.rdata = BYTE_ZERO;
		if (!i_cpu_rd) begin
			state_d.rdata = BYTE_ZERO;
		end else if (i_cpu_addr == ADDR_TX_CTRL) begin
			state_d.rdata = {5'h00, state_q.tx_ctrl};
		end else if (i_cpu_addr == ADDR_RX_STATUS) begin
			state_d.rdata[BIT_ONCE_MODE]  = state_q.once_mode;
			state_d.rdata[BIT_ALARM_STAT] = i_rx_line_alarm; // R6
			state_d.rdata[BIT_RDI_STAT]   = i_rx_remote_defect; // R7
		end else if (i_cpu_addr == ADDR_RX_IRQ) begin
			state_d.rdata = {state_q.irq_en, state_q.flags};
		end else if (i_cpu_addr == ADDR_B2_LOW) begin
			state_d.rdata = state_q.b2_hold[7:0]; // R16
		end else if (i_cpu_addr == ADDR_B2_MID) begin
			state_d.rdata = state_q.b2_hold[15:8]; // R16
		end else if (i_cpu_addr == ADDR_B2_HIGH) begin
			state_d.rdata = {4'h0, state_q.b2_hold[19:16]};
		end else if (i_cpu_addr == ADDR_FEBE_LOW) begin
			state_d.rdata = state_q.febe_hold[7:0];
		end else if (i_cpu_addr == ADDR_FEBE_MID) begin
			state_d.rdata = state_q.febe_hold[15:8]; // R17
		end else if (i_cpu_addr == ADDR_FEBE_HIGH) begin
			state_d.rdata = {4'h0, state_q.febe_hold[19:16]};
		end

		// Enables at bits 7:4 mask flags at bits 3:0
		state_d.irq = |(state_q.flags & state_q.irq_en); // R8 R9 R10 R11 R20
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign o_cpu_rdata  = state_q.rdata;
	assign o_cpu_rvalid = state_q.rvalid;
	assign o_irq        = state_q.irq;
	assign o_tx_byte    = state_q.tx_byte;

	// ==========================================
	// Checks
	a_force_zero: assert property ( // R1
		@(posedge i_clock) disable iff (!i_rstn)
		state_q.tx_ctrl[BIT_FORCE_ZERO] |=> (o_tx_byte == BYTE_ZERO)
	) else $error("tx byte not zero while forced");

	a_b1_invert: assert property ( // R2
		@(posedge i_clock) disable iff (!i_rstn)
		!state_q.tx_ctrl[BIT_FORCE_ZERO] && state_q.tx_ctrl[BIT_B1_INVERT] && i_tx_is_b1
		|=> (o_tx_byte == ~$past(i_tx_byte))
	) else $error("b1 byte not inverted");

	a_a1_corrupt: assert property ( // R3
		@(posedge i_clock) disable iff (!i_rstn)
		!state_q.tx_ctrl[BIT_FORCE_ZERO] && !(i_tx_is_b1 && state_q.tx_ctrl[BIT_B1_INVERT])
		&& state_q.tx_ctrl[BIT_A1_CORRUPT] && i_tx_is_a1
		|=> (o_tx_byte == ($past(i_tx_byte) ^ A1_MSB_MASK))
	) else $error("a1 msb not flipped");

	a_once_count: assert property ( // R4
		@(posedge i_clock) disable iff (!i_rstn)
		i_rx_frame_end && state_q.once_mode && (i_rx_b2_errs != NO_ERR) && !poll
		|=> (state_q.b2_acc == $past(state_q.b2_acc) + 20'h00001)
	) else $error("once mode did not add one");

	a_sum_count: assert property ( // R5
		@(posedge i_clock) disable iff (!i_rstn)
		i_rx_frame_end && !state_q.once_mode && !poll && (i_rx_b2_errs <= MAX_ERR_STS1)
		|=> (state_q.b2_acc == $past(state_q.b2_acc) + CNT_W'($past(i_rx_b2_errs)))
	) else $error("frame error sum wrong");

	a_status_read: assert property ( // R6 R7
		@(posedge i_clock) disable iff (!i_rstn)
		i_cpu_rd && (i_cpu_addr == ADDR_RX_STATUS)
		|=> (o_cpu_rdata[1:0] == $past({i_rx_line_alarm, i_rx_remote_defect}))
	) else $error("status bits mismatch");

	a_alarm_flag: assert property ( // R14
		@(posedge i_clock) disable iff (!i_rstn)
		(i_rx_line_alarm != state_q.alarm_prev) |=> state_q.flags[FLAG_ALARM]
	) else $error("alarm change not flagged");

	a_febe_flag: assert property ( // R12
		@(posedge i_clock) disable iff (!i_rstn)
		i_rx_frame_end && (i_rx_febe_errs != NO_ERR) |=> state_q.flags[FLAG_FEBE]
	) else $error("far-end error not flagged");

	a_flag_clear: assert property ( // R13
		@(posedge i_clock) disable iff (!i_rstn)
		irq_read && (events == '0) |=> (state_q.flags == '0)
	) else $error("flags not cleared by read");

	a_irq_out: assert property ( // R20
		@(posedge i_clock) disable iff (!i_rstn)
		|(state_q.flags & state_q.irq_en) |=> o_irq
	) else $error("irq missing for enabled flag");

	a_irq_quiet: assert property ( // R9
		@(posedge i_clock) disable iff (!i_rstn)
		((state_q.flags & state_q.irq_en) == '0) |=> !o_irq
	) else $error("irq without enabled flag");

	a_poll_hold: assert property ( // R18 R19
		@(posedge i_clock) disable iff (!i_rstn)
		poll |=> (state_q.b2_acc == CNT_RST)
		&& (state_q.b2_hold == $past(state_q.b2_acc) + CNT_W'($past(b2_inc)))
	) else $error("poll transfer wrong");

	a_febe_poll: assert property ( // R18 R19
		@(posedge i_clock) disable iff (!i_rstn)
		poll |=> (state_q.febe_acc == CNT_RST)
		&& (state_q.febe_hold == $past(state_q.febe_acc) + CNT_W'($past(febe_inc)))
	) else $error("far-end poll transfer wrong");

	a_rdi_flag: assert property ( // R15
		@(posedge i_clock) disable iff (!i_rstn)
		(i_rx_remote_defect != state_q.rdi_prev) |=> state_q.flags[FLAG_RDI]
	) else $error("defect change not flagged");

	a_b2_flag: assert property ( // R13
		@(posedge i_clock) disable iff (!i_rstn)
		i_rx_frame_end && (i_rx_b2_errs != NO_ERR) |=> state_q.flags[FLAG_B2]
	) else $error("parity error not flagged");

	a_flag_hold: assert property ( // R12 R13 R14 R15
		@(posedge i_clock) disable iff (!i_rstn)
		!irq_read |=> ((state_q.flags & $past(state_q.flags)) == $past(state_q.flags))
	) else $error("flag dropped without read");

	a_clip_slow: assert property ( // R5
		@(posedge i_clock) disable iff (!i_rstn)
		i_rx_frame_end && !state_q.once_mode && !poll
		&& i_rate_sts1 && (i_rx_b2_errs > MAX_ERR_STS1)
		|=> (state_q.b2_acc == $past(state_q.b2_acc) + CNT_W'(MAX_ERR_STS1))
	) else $error("low rate clip wrong");

	a_clip_fast: assert property ( // R5
		@(posedge i_clock) disable iff (!i_rstn)
		i_rx_frame_end && !state_q.once_mode && !poll
		&& !i_rate_sts1 && (i_rx_b2_errs > MAX_ERR_STS3C)
		|=> (state_q.b2_acc == $past(state_q.b2_acc) + CNT_W'(MAX_ERR_STS3C))
	) else $error("high rate clip wrong");

	a_acc_stable: assert property ( // R16
		@(posedge i_clock) disable iff (!i_rstn)
		!i_rx_frame_end && !poll |=> $stable(state_q.b2_acc) && $stable(state_q.febe_acc)
	) else $error("counter moved without frame");

	a_tx_pass: assert property ( // R1 R2 R3
		@(posedge i_clock) disable iff (!i_rstn)
		!state_q.tx_ctrl[BIT_FORCE_ZERO] && !(i_tx_is_b1 && state_q.tx_ctrl[BIT_B1_INVERT])
		&& !(i_tx_is_a1 && state_q.tx_ctrl[BIT_A1_CORRUPT])
		|=> (o_tx_byte == $past(i_tx_byte))
	) else $error("tx byte altered without control");

	a_ctrl_write: assert property ( // R1 R2 R3
		@(posedge i_clock) disable iff (!i_rstn)
		i_cpu_wr && (i_cpu_addr == ADDR_TX_CTRL)
		|=> (state_q.tx_ctrl == $past(i_cpu_wdata[TXC_W-1:0]))
	) else $error("control write lost");

	a_enable_write: assert property ( // R8 R9 R10 R11
		@(posedge i_clock) disable iff (!i_rstn)
		i_cpu_wr && (i_cpu_addr == ADDR_RX_IRQ)
		|=> (state_q.irq_en == $past(i_cpu_wdata[IRQ_EN_LSB +: IRQ_W]))
	) else $error("enable write lost");

	a_irq_read: assert property ( // R12 R13 R14 R15
		@(posedge i_clock) disable iff (!i_rstn)
		irq_read |=> (o_cpu_rdata == $past({state_q.irq_en, state_q.flags}))
	) else $error("interrupt register read wrong");

	a_b2_low_read: assert property ( // R16
		@(posedge i_clock) disable iff (!i_rstn)
		i_cpu_rd && (i_cpu_addr == ADDR_B2_LOW)
		|=> (o_cpu_rdata == $past(state_q.b2_hold[7:0]))
	) else $error("parity count low byte wrong");

	a_febe_mid_read: assert property ( // R17
		@(posedge i_clock) disable iff (!i_rstn)
		i_cpu_rd && (i_cpu_addr == ADDR_FEBE_MID)
		|=> (o_cpu_rdata == $past(state_q.febe_hold[15:8]))
	) else $error("far-end count middle byte wrong");

	a_read_answer: assert property ( // R16 R17
		@(posedge i_clock) disable iff (!i_rstn)
		i_cpu_rd |=> o_cpu_rvalid
	) else $error("read not answered");

	a_read_idle: assert property ( // R16 R17
		@(posedge i_clock) disable iff (!i_rstn)
		!i_cpu_rd |=> !o_cpu_rvalid && (o_cpu_rdata == BYTE_ZERO)
	) else $error("read answer without request");

endmodule

// >>> dv/slom_far_end.sv
module slom_far_end (
	input  wire logic                     i_clock,
	output logic                          o_frame_end,
	output logic [slom_pkg::ERR_W-1:0]    o_b2_errs,
	output logic [slom_pkg::ERR_W-1:0]    o_febe_errs,
	output logic                          o_alarm,
	output logic                          o_defect
);
	timeunit 1ns;
	timeprecision 1ps;
	import slom_pkg::*;
	initial begin
		o_frame_end = 1'b0;
		o_b2_errs = '1;
		o_febe_errs = '1;
		o_alarm = 1'b0;
		o_defect = 1'b0;
	end
	// Counts only hold with the frame pulse
	task automatic frame(input logic [ERR_W-1:0] b2, input logic [ERR_W-1:0] fe);
		@(posedge i_clock);
		#1;
		o_frame_end = 1'b1;
		o_b2_errs = b2;
		o_febe_errs = fe;
		@(posedge i_clock);
		#1;
		o_frame_end = 1'b0;
		o_b2_errs = ~b2;
		o_febe_errs = ~fe;
	endtask
endmodule

// >>> dv/sonet_line_overhead_monitor_test.sv
module sonet_line_overhead_monitor_test;
	timeunit 1ns;
	timeprecision 1ps;
	import slom_pkg::*;
	logic clk = 0, rstn = 0, rd = 0, wr = 0, a1 = 0, b1 = 0, sts1 = 1;
	logic [7:0] addr = 0, wd = 0, tb = 0, rdata, txo, ctl = 0, e;
	logic rv, irq, fe_end, al, df;
	logic [ERR_W-1:0] b2e, fee;
	logic [7:0] exp_q[$], tx_q[$];
	int n_fail = 0, total_checks = 0, i, k;
	always #4 clk = ~clk;
	slom_far_end far (.i_clock(clk), .o_frame_end(fe_end), .o_b2_errs(b2e),
		.o_febe_errs(fee), .o_alarm(al), .o_defect(df));
	slom_top DUT (.i_clock(clk), .i_rstn(rstn), .i_cpu_rd(rd), .i_cpu_wr(wr),
		.i_cpu_addr(addr), .i_cpu_wdata(wd), .o_cpu_rdata(rdata), .o_cpu_rvalid(rv),
		.o_irq(irq), .i_tx_byte(tb), .i_tx_is_a1(a1), .i_tx_is_b1(b1), .o_tx_byte(txo),
		.i_rate_sts1(sts1), .i_rx_frame_end(fe_end), .i_rx_b2_errs(b2e),
		.i_rx_febe_errs(fee), .i_rx_line_alarm(al), .i_rx_remote_defect(df));
	task automatic check8(input logic [7:0] got, input logic [7:0] ex, input string m);
		total_checks++;
		if (got !== ex) begin
			n_fail++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, ex);
		end
	endtask
	task automatic check_tx(input logic [7:0] ex);
		check8(txo, ex, "tx byte");
	endtask
	task automatic check_irq(input logic ex, input string m);
		check8({7'h00, irq}, {7'h00, ex}, m);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Scoreboard: oldest note against each result
	always @(negedge clk) begin
		if (rv === 1'b1) begin
			if (exp_q.size() == 0) check8(rdata, 8'hxx, "read answer with no request");
			else check8(rdata, exp_q.pop_front(), "read data");
		end
		if (tx_q.size() != 0) check_tx(tx_q.pop_front());
	end
	task automatic cpu_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		wr = 1;
		addr = a;
		wd = d;
		@(posedge clk);
		#1;
		wr = 0;
		wd = ~d;
	endtask
	task automatic cpu_rd(input logic [7:0] a, input logic [7:0] ex);
		@(posedge clk);
		#1;
		rd = 1;
		addr = a;
		@(posedge clk);
		#1;
		rd = 0;
		exp_q.push_back(ex);
	endtask
	task automatic send_tx(input logic [7:0] b, input logic isa1, input logic isb1);
		@(posedge clk);
		#1;
		tb = b;
		a1 = isa1;
		b1 = isb1;
		e = ctl[2] ? 8'h00 : (isb1 && ctl[1]) ? ~b : (isa1 && ctl[0]) ? b ^ 8'h80 : b;
		@(posedge clk);
		#1;
		tx_q.push_back(e);
	endtask
	task automatic ev(input int j);
		case (j)
			3: far.frame(5'h00, 5'h01);
			2: far.frame(5'h01, 5'h00);
			1: far.o_alarm = ~far.o_alarm;
			default: far.o_defect = ~far.o_defect;
		endcase
		repeat (3) @(posedge clk);
		#1;
	endtask
	initial begin
		#200000;
		n_fail++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'h90f9));
		repeat (5) @(posedge clk);
		#1;
		rstn = 1;
		cpu_rd(ADDR_TX_CTRL, 8'h00);
		cpu_rd(ADDR_RX_IRQ, 8'h00);
		cpu_rd(8'h30, 8'h00);
		for (i = 0; i < 8; i++) begin
			cpu_wr(ADDR_TX_CTRL, 8'hf8 | i);
			ctl = i;
			cpu_rd(ADDR_TX_CTRL, ctl);
			for (k = 0; k < 4; k++) send_tx($urandom, k[0], k[1]);
			send_tx(8'hf6, 1, 0);
		end
		cpu_wr(ADDR_RX_STATUS, 8'h00);
		far.frame(5'h03, 5'h00);
		far.frame(5'h0c, 5'h00);
		cpu_wr(ADDR_MASTER_POLL, 8'h00);
		cpu_rd(ADDR_B2_LOW, 8'h0b);
		cpu_wr(ADDR_RX_STATUS, 8'h80);
		cpu_rd(ADDR_RX_STATUS, 8'h80);
		far.frame(5'h03, 5'h00);
		far.frame(5'h00, 5'h00);
		far.frame(5'h05, 5'h00);
		cpu_wr(ADDR_B2_LOW, 8'h00);
		cpu_rd(ADDR_B2_LOW, 8'h02);
		cpu_wr(ADDR_RX_STATUS, 8'h00);
		sts1 = 0;
		repeat (13) far.frame(5'h1e, 5'h14);
		cpu_wr(ADDR_FEBE_MID, 8'h00);
		cpu_rd(ADDR_B2_LOW, 8'h38);
		cpu_rd(ADDR_B2_MID, 8'h01);
		cpu_rd(ADDR_FEBE_MID, 8'h01);
		check_irq(1'b0, "irq with enables off");
		cpu_rd(ADDR_RX_IRQ, 8'h0c);
		cpu_rd(ADDR_RX_IRQ, 8'h00);
		for (i = 0; i < 4; i++) begin
			cpu_wr(ADDR_RX_IRQ, 8'h10 << i);
			ev((i + 1) % 4);
			check_irq(1'b0, "irq from masked flag");
			cpu_rd(ADDR_RX_IRQ, (8'h10 << i) | (8'h01 << ((i + 1) % 4)));
			ev(i);
			check_irq(1'b1, "irq from enabled flag");
			cpu_rd(ADDR_RX_IRQ, (8'h10 << i) | (8'h01 << i));
			repeat (2) @(posedge clk);
			#1;
			check_irq(1'b0, "irq after clear");
		end
		// Frame end and poll write on one edge
		fork
			far.frame(5'h04, 5'h03);
			cpu_wr(ADDR_B2_HIGH, 8'h00);
		join
		cpu_rd(ADDR_B2_LOW, 8'h06);
		cpu_rd(ADDR_B2_HIGH, 8'h00);
		cpu_rd(ADDR_FEBE_LOW, 8'h05);
		cpu_rd(ADDR_FEBE_HIGH, 8'h00);
		check_irq(1'b1, "irq from far-end flag");
		cpu_rd(ADDR_RX_STATUS, {6'h00, al, df});
		for (k = 0; k < 20 && exp_q.size() + tx_q.size() != 0; k++) @(posedge clk);
		if (k == 20) n_fail++;
		print_verdict();
	end
endmodule
